// ### rrs_cfg.svh
// constants for the return/rotate/sleep execution block
`ifndef RRS_CFG_SVH
`define RRS_CFG_SVH

// ----------------------------------------------------------------------
// opcode encodings
// ----------------------------------------------------------------------
`define RRS_OP_RET_IRQ  14'h0009
`define RRS_OP_RETURN   14'h0008
`define RRS_OP_SLEEP    14'h0063
`define RRS_RET_LIT_HI  4'hD
`define RRS_ROTL_HI     6'h0D
`define RRS_DEST_BIT    7

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define RRS_A_CTRL      8'h00
`define RRS_A_STATUS    8'h04
`define RRS_A_WREG      8'h08
`define RRS_A_PC        8'h0C
`define RRS_A_INTCTL    8'h10
`define RRS_A_STACK     8'h14
`define RRS_A_FADDR     8'h18
`define RRS_A_FDATA     8'h1C
`define RRS_A_WDOG      8'h20
`define RRS_A_IRQ_STAT  8'h24
`define RRS_A_IRQ_MASK  8'h28

// ----------------------------------------------------------------------
// field positions, reset values and bus response codes
// ----------------------------------------------------------------------
`define RRS_IRQ_EN_BIT  7
`define RRS_CTRL_WAKE   0
`define RRS_ST_CARRY    0
`define RRS_ST_PWRDN    3
`define RRS_ST_TMOUT    4
`define RRS_ST_SLEEP    5
`define RRS_IRQ_RET     0
`define RRS_IRQ_ROT     1
`define RRS_IRQ_SLP     2
`define RRS_PC_RESET    13'h0000
`define RRS_RESP_OKAY   2'h0
`define RRS_RESP_SLVERR 2'h2

`endif

// ### rrs_pkg.sv
// types shared by the return/rotate/sleep execution block
package rrs_pkg;
  typedef enum logic [2:0] {
    RRS_OP_NONE, RRS_OP_RET_IRQ, RRS_OP_RETURN,
    RRS_OP_RET_LIT, RRS_OP_ROTL, RRS_OP_SLEEP
  } rrs_op_t;

  typedef enum logic [1:0] {RRS_RUN, RRS_POP2, RRS_SLEEP} rrs_state_t;
endpackage

// ### rrs_rotl.sv
// left rotation of one byte through the carry flag
`timescale 1ns/1ps
`include "rrs_cfg.svh"
module rrs_rotl (
  input  wire logic [7:0] value,
  input  wire logic       carry_in,
  output logic      [7:0] result,
  output logic            carry_out
);
  always_comb begin
    result    = {value[6:0], carry_in};
    carry_out = value[7];
  end
endmodule

// ### rrs_exec.sv
// execution of return, rotate-left and sleep opcodes with an AXI4-Lite port
// Contract
// - interrupt return pops stack into PC, two cycles, flags unchanged
// - interrupt return also sets global_irq_enable, bit 7
// - subroutine return pops stack into PC, two cycles, enables kept
// - literal return loads 8-bit immediate into W and pops PC
// - left rotate of file register through carry, only carry changes
// - destination bit 0 writes W, 1 writes file register back
// - rotate decodes 7-bit file address and destination bit
// - sleep clears power_down_flag
// - sleep sets timeout_flag
// - sleep clears watchdog counter and its prescaler
// - sleep enters low-power mode and stops the oscillator
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "rrs_cfg.svh"
module rrs_exec (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [13:0] opcode,
  input  wire logic        opcode_valid,
  output logic             opcode_ready,
  output logic      [12:0] pc,
  output logic             osc_run,
  output logic             irq,
  input  wire logic  [7:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic  [3:0] s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic       [1:0] s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic  [7:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic       [1:0] s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  rrs_pkg::rrs_state_t state_q;
  logic        ready_q;
  logic        osc_q;
  logic [12:0] pc_q;
  logic [12:0] stack_q [8];
  logic  [2:0] sp_q;
  logic  [7:0] file_q [128];
  logic  [7:0] w_q;
  logic  [7:0] intctl_q;
  logic        carry_q;
  logic        pwrdn_q;
  logic        tmout_q;
  logic  [7:0] wdog_q;
  logic  [7:0] pre_q;
  logic  [6:0] faddr_q;
  logic  [2:0] irq_stat_q;
  logic  [2:0] irq_mask_q;
  logic        irq_q;
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic  [1:0] bresp_q;
  logic  [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic  [3:0] wstrb_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic  [1:0] rresp_q;

  assign opcode_ready  = ready_q;
  assign pc            = pc_q;
  assign osc_run       = osc_q;
  assign irq           = irq_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // --------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------
  function automatic rrs_pkg::rrs_op_t rrs_decode(input logic [13:0] op);
    if (op == `RRS_OP_RET_IRQ) return rrs_pkg::RRS_OP_RET_IRQ;
    if (op == `RRS_OP_RETURN) return rrs_pkg::RRS_OP_RETURN;
    if (op == `RRS_OP_SLEEP) return rrs_pkg::RRS_OP_SLEEP;
    if (op[13:10] == `RRS_RET_LIT_HI) return rrs_pkg::RRS_OP_RET_LIT;
    if (op[13:8] == `RRS_ROTL_HI) return rrs_pkg::RRS_OP_ROTL;
    return rrs_pkg::RRS_OP_NONE;
  endfunction

  function automatic logic rrs_is_ret(input rrs_pkg::rrs_op_t k);
    return k == rrs_pkg::RRS_OP_RET_IRQ || k == rrs_pkg::RRS_OP_RETURN ||
           k == rrs_pkg::RRS_OP_RET_LIT;
  endfunction

  rrs_pkg::rrs_op_t kind;
  logic        take;
  logic        is_ret;
  logic  [2:0] sp_pop;
  logic [12:0] top;
  logic  [6:0] f_addr;
  logic        f_dest;
  logic  [7:0] rot_res;
  logic        rot_carry;

  assign kind   = rrs_decode(opcode);
  assign take   = ce && opcode_valid && ready_q;
  assign is_ret = rrs_is_ret(kind);
  assign sp_pop = sp_q - 3'h1;
  assign top    = stack_q[sp_pop];
  assign f_addr = opcode[6:0];
  assign f_dest = opcode[`RRS_DEST_BIT];

  rrs_rotl u_rotl (
    .value     (file_q[f_addr]),
    .carry_in  (carry_q),
    .result    (rot_res),
    .carry_out (rot_carry)
  );

  // --------------------------------------------------------------------
  // register bus decode
  // --------------------------------------------------------------------
  function automatic logic [31:0] rrs_read(input logic [7:0] a);
    case (a)
      `RRS_A_STATUS: return {21'h000000, sp_q, 2'h0,
                             state_q == rrs_pkg::RRS_SLEEP, tmout_q, pwrdn_q,
                             2'h0, carry_q};
      `RRS_A_WREG:     return {24'h000000, w_q};
      `RRS_A_PC:       return {19'h00000, pc_q};
      `RRS_A_INTCTL:   return {24'h000000, intctl_q};
      `RRS_A_STACK:    return {19'h00000, top};
      `RRS_A_FADDR:    return {25'h0000000, faddr_q};
      `RRS_A_FDATA:    return {24'h000000, file_q[faddr_q]};
      `RRS_A_WDOG:     return {16'h0000, pre_q, wdog_q};
      `RRS_A_IRQ_STAT: return {29'h00000000, irq_stat_q};
      `RRS_A_IRQ_MASK: return {29'h00000000, irq_mask_q};
      default:         return 32'h00000000;
    endcase
  endfunction

  function automatic logic rrs_mapped(input logic [7:0] a);
    return a <= `RRS_A_IRQ_MASK && a[1:0] == 2'h0;
  endfunction

  logic        wr_en;
  logic [31:0] wr_cur;
  logic [31:0] wr_val;
  always_comb begin
    wr_en  = ce && !awready_q && !wready_q && !bvalid_q;
    wr_cur = rrs_read(awaddr_q);
    for (int i = 0; i < 4; i++) begin
      wr_val[i*8 +: 8] = wstrb_q[i] ? wdata_q[i*8 +: 8] : wr_cur[i*8 +: 8];
    end
  end

  function automatic logic wr_hit(input logic [7:0] a);
    return wr_en && awaddr_q == a;
  endfunction

  // --------------------------------------------------------------------
  // AXI4-Lite write channel: one write at a time
  // --------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RRS_RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && awready_q) begin
        awaddr_q  <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (wr_en) begin
        bvalid_q <= 1'b1;
        bresp_q  <= rrs_mapped(awaddr_q) ? `RRS_RESP_OKAY
                                         : `RRS_RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------
  logic rd_take;
  assign rd_take = ce && s_axi_arvalid && arready_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= `RRS_RESP_OKAY;
    end else if (ce) begin
      if (rd_take) begin
        rdata_q   <= rrs_read(s_axi_araddr);
        rresp_q   <= rrs_mapped(s_axi_araddr) ? `RRS_RESP_OKAY
                                              : `RRS_RESP_SLVERR;
        rvalid_q  <= 1'b1;
        arready_q <= 1'b0;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // sequencer: returns hold the port for a second cycle, sleep holds it
  // until software wakes the core
  // --------------------------------------------------------------------
  logic wake;
  // written out: a continuous assign would not follow the globals of wr_hit
  assign wake = wr_en && awaddr_q == `RRS_A_CTRL && wr_val[`RRS_CTRL_WAKE];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= rrs_pkg::RRS_RUN;
      ready_q <= 1'b1;
      osc_q   <= 1'b1;
    end else if (ce) begin
      case (state_q)
        rrs_pkg::RRS_RUN: begin
          if (take && is_ret) begin
            state_q <= rrs_pkg::RRS_POP2;
            ready_q <= 1'b0;
          end else if (take && kind == rrs_pkg::RRS_OP_SLEEP) begin
            state_q <= rrs_pkg::RRS_SLEEP;
            ready_q <= 1'b0;
            osc_q   <= 1'b0;
          end
        end
        rrs_pkg::RRS_POP2: begin
          state_q <= rrs_pkg::RRS_RUN;
          ready_q <= 1'b1;
        end
        rrs_pkg::RRS_SLEEP: begin
          if (wake) begin
            state_q <= rrs_pkg::RRS_RUN;
            ready_q <= 1'b1;
            osc_q   <= 1'b1;
          end
        end
        default: begin
          state_q <= rrs_pkg::RRS_RUN;
          ready_q <= 1'b1;
          osc_q   <= 1'b1;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // program counter and stack; an executed pop beats a bus push
  // --------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= `RRS_PC_RESET;
      sp_q <= 3'h0;
    end else if (ce) begin
      if (take && is_ret) begin
        pc_q <= top;
        sp_q <= sp_pop;
      end else if (take && kind != rrs_pkg::RRS_OP_SLEEP) begin
        pc_q <= pc_q + 13'h0001;
      end else if (wr_hit(`RRS_A_PC)) begin
        pc_q <= wr_val[12:0];
      end
      if (!(take && is_ret) && wr_hit(`RRS_A_STACK)) begin
        sp_q <= sp_q + 3'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (ce && !(take && is_ret) && wr_hit(`RRS_A_STACK)) begin
      stack_q[sp_q] <= wr_val[12:0];
    end
  end

  // --------------------------------------------------------------------
  // file registers; a rotate write-back beats a bus write
  // --------------------------------------------------------------------
  logic rot_take;
  assign rot_take = take && kind == rrs_pkg::RRS_OP_ROTL;

  always_ff @(posedge aclk) begin
    if (ce) begin
      if (rot_take && f_dest) begin
        file_q[f_addr] <= rot_res;
      end else if (wr_hit(`RRS_A_FDATA)) begin
        file_q[faddr_q] <= wr_val[7:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      faddr_q <= 7'h00;
    end else if (wr_hit(`RRS_A_FADDR)) begin
      faddr_q <= wr_val[6:0];
    end
  end

  // --------------------------------------------------------------------
  // W, carry and interrupt control
  // --------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_q <= 8'h00;
    end else if (ce) begin
      if (take && kind == rrs_pkg::RRS_OP_RET_LIT) begin
        w_q <= opcode[7:0];
      end else if (rot_take && !f_dest) begin
        w_q <= rot_res;
      end else if (wr_hit(`RRS_A_WREG)) begin
        w_q <= wr_val[7:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carry_q <= 1'b0;
    end else if (ce) begin
      if (rot_take) begin
        carry_q <= rot_carry;
      end else if (wr_hit(`RRS_A_STATUS)) begin
        carry_q <= wr_val[`RRS_ST_CARRY];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      intctl_q <= 8'h00;
    end else if (ce) begin
      if (wr_hit(`RRS_A_INTCTL)) begin
        intctl_q <= wr_val[7:0];
      end
      if (take && kind == rrs_pkg::RRS_OP_RET_IRQ) begin
        intctl_q[`RRS_IRQ_EN_BIT] <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // power flags and watchdog; the watchdog keeps counting in sleep
  // --------------------------------------------------------------------
  logic slp_take;
  assign slp_take = take && kind == rrs_pkg::RRS_OP_SLEEP;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwrdn_q <= 1'b1;
      tmout_q <= 1'b1;
      wdog_q  <= 8'h00;
      pre_q   <= 8'h00;
    end else if (ce) begin
      if (slp_take) begin
        pwrdn_q <= 1'b0;
        tmout_q <= 1'b1;
        wdog_q  <= 8'h00;
        pre_q   <= 8'h00;
      end else begin
        pre_q <= pre_q + 8'h01;
        if (pre_q == 8'hFF) begin
          wdog_q <= wdog_q + 8'h01;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // interrupts: a new event wins over the clearing read
  // --------------------------------------------------------------------
  logic [2:0] ev;
  logic       stat_rd;
  assign ev[`RRS_IRQ_RET] = take && is_ret;
  assign ev[`RRS_IRQ_ROT] = rot_take;
  assign ev[`RRS_IRQ_SLP] = slp_take;
  assign stat_rd = rd_take && s_axi_araddr == `RRS_A_IRQ_STAT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= 3'h0;
      irq_mask_q <= 3'h0;
      irq_q      <= 1'b0;
    end else if (ce) begin
      irq_stat_q <= (stat_rd ? 3'h0 : irq_stat_q) | ev;
      if (wr_hit(`RRS_A_IRQ_MASK)) begin
        irq_mask_q <= wr_val[2:0];
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  property p_ret_pc;
    @(posedge aclk) disable iff (!aresetn || !ce)
    (take && is_ret) |=> pc_q == $past(top);
  endproperty
  a_ret_pc: assert property (p_ret_pc)
    else $error("return did not load pc from stack top");

  property p_ret_two;
    @(posedge aclk) disable iff (!aresetn || !ce)
    (take && is_ret) |=> !ready_q ##1 ready_q;
  endproperty
  a_ret_two: assert property (p_ret_two)
    else $error("return did not take two cycles");

  property p_iret_enable;
    @(posedge aclk) disable iff (!aresetn || !ce)
    (take && kind == rrs_pkg::RRS_OP_RET_IRQ) |=>
      intctl_q[`RRS_IRQ_EN_BIT];
  endproperty
  a_iret_enable: assert property (p_iret_enable)
    else $error("interrupt return left enable clear");

  property p_return_keeps;
    @(posedge aclk) disable iff (!aresetn || !ce)
    (take && kind == rrs_pkg::RRS_OP_RETURN && !wr_en) |=>
      $stable(intctl_q) && $stable(carry_q) && $stable(w_q);
  endproperty
  a_return_keeps: assert property (p_return_keeps)
    else $error("subroutine return changed flags");

  property p_lit_w;
    @(posedge aclk) disable iff (!aresetn || !ce)
    (take && kind == rrs_pkg::RRS_OP_RET_LIT) |=> w_q == $past(opcode[7:0]);
  endproperty
  a_lit_w: assert property (p_lit_w)
    else $error("literal return did not load W");

  property p_pop_sp;
    @(posedge aclk) disable iff (!aresetn || !ce)
    (take && is_ret) |=> sp_q == $past(sp_q) - 3'h1;
  endproperty
  a_pop_sp: assert property (p_pop_sp)
    else $error("stack pointer not decremented");

  property p_rot_w;
    @(posedge aclk) disable iff (!aresetn || !ce)
    (rot_take && !f_dest) |=> w_q == {$past(file_q[f_addr][6:0]),
                                      $past(carry_q)} &&
                              carry_q == $past(file_q[f_addr][7]);
  endproperty
  a_rot_w: assert property (p_rot_w)
    else $error("rotate to W wrong");

  property p_rot_f;
    @(posedge aclk) disable iff (!aresetn || !ce)
    (rot_take && f_dest) |=> file_q[$past(f_addr)] ==
      {$past(file_q[f_addr][6:0]), $past(carry_q)} && $stable(w_q);
  endproperty
  a_rot_f: assert property (p_rot_f)
    else $error("rotate to file register wrong");

  property p_sleep;
    @(posedge aclk) disable iff (!aresetn || !ce)
    slp_take |=> !pwrdn_q && tmout_q && wdog_q == 8'h00 && pre_q == 8'h00 &&
                 !osc_q && !ready_q;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep entry wrong");
endmodule

// ### test_rrs_exec.sv
// self-checking testbench for the return/rotate/sleep execution block
`timescale 1ns/1ps
`include "rrs_cfg.svh"
module test_rrs_exec;
  logic        aclk;
  logic        aresetn;
  logic        ce;
  logic [13:0] opcode;
  logic        opcode_valid;
  logic        opcode_ready;
  logic [12:0] pc;
  logic        osc_run;
  logic        irq;
  logic  [7:0] s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic  [3:0] s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic  [1:0] s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic  [7:0] s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic  [1:0] s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  int          errors;
  int          comparisons;
  logic [31:0] rd;
  logic  [1:0] rs;

  rrs_exec dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .opcode(opcode),
    .opcode_valid(opcode_valid), .opcode_ready(opcode_ready), .pc(pc),
    .osc_run(osc_run), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );

  // ----------------------------------------------------------------------
  // clock
  // ----------------------------------------------------------------------
  initial aclk = 1'b0;
  always #50 aclk = ~aclk;

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic timeout(input string name);
    errors++;
    $display("[FAIL] %s expected handshake seen none", name);
    results();
  endtask

  // called right after a rising edge; returns at the response edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] resp);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    if (!s_axi_bvalid) timeout("write response");
    resp = s_axi_bresp;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    if (!s_axi_rvalid) timeout("read data");
    d = s_axi_rdata;
    resp = s_axi_rresp;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, rs);
    check("write response", {30'h0, rs}, {30'h0, `RRS_RESP_OKAY});
  endtask

  // offers one opcode and returns at the edge where it is taken
  task automatic send_op(input logic [13:0] op);
    int n;
    n = 0;
    opcode       <= op;
    opcode_valid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!opcode_ready && n < 50);
    if (!opcode_ready) timeout("opcode take");
    opcode_valid <= 1'b0;
  endtask

  // samples the cycle that follows the take edge
  task automatic after_op(input logic [12:0] exp_pc, input logic exp_rdy);
    @(posedge aclk);
    check("pc", {19'h0, pc}, {19'h0, exp_pc});
    check("opcode_ready", {31'h0, opcode_ready}, {31'h0, exp_rdy});
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    errors = 0;
    comparisons = 0;
    aresetn = 1'b0;
    ce = 1'b1;
    opcode = 14'h0000;
    opcode_valid = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(`RRS_A_STATUS, rd, rs);
    check("flags after reset", {30'h0, rd[4:3]}, 32'h3);
    check("pc after reset", {19'h0, pc}, 32'h0);
    wr(`RRS_A_IRQ_MASK, 32'h7);
    wr(`RRS_A_STACK, 32'h123);
    wr(`RRS_A_STACK, 32'h456);
    wr(`RRS_A_INTCTL, 32'h0);
    send_op(`RRS_OP_RETURN);
    after_op(13'h0456, 1'b0);
    axi_read(`RRS_A_INTCTL, rd, rs);
    check("enable kept", rd, 32'h0);
    axi_read(`RRS_A_STACK, rd, rs);
    check("new top", rd, 32'h123);
    axi_read(`RRS_A_STATUS, rd, rs);
    check("stack pointer", {29'h0, rd[10:8]}, 32'h1);
    send_op(`RRS_OP_RET_IRQ);
    after_op(13'h0123, 1'b0);
    axi_read(`RRS_A_INTCTL, rd, rs);
    check("global enable", rd, 32'h80);
    // the literal return runs after the bus push and a write that clears W
    wr(`RRS_A_STACK, 32'h777);
    wr(`RRS_A_WREG, 32'h0);
    send_op({`RRS_RET_LIT_HI, 2'b11, 8'hA5});
    after_op(13'h0777, 1'b0);
    axi_read(`RRS_A_WREG, rd, rs);
    check("literal in W", rd, 32'hA5);
    // rotate at the top file address, carry clear then set
    wr(`RRS_A_FADDR, 32'h7F);
    wr(`RRS_A_FDATA, 32'hE6);
    wr(`RRS_A_STATUS, 32'h0);
    send_op({`RRS_ROTL_HI, 1'b0, 7'h7F});
    after_op(13'h0778, 1'b1);
    axi_read(`RRS_A_WREG, rd, rs);
    check("rotate to W", rd, 32'hCC);
    axi_read(`RRS_A_FDATA, rd, rs);
    check("source kept", rd, 32'hE6);
    axi_read(`RRS_A_STATUS, rd, rs);
    check("carry out", {31'h0, rd[0]}, 32'h1);
    send_op({`RRS_ROTL_HI, 1'b1, 7'h7F});
    after_op(13'h0779, 1'b1);
    axi_read(`RRS_A_FDATA, rd, rs);
    check("rotate to file", rd, 32'hCD);
    axi_read(`RRS_A_WREG, rd, rs);
    check("W kept", rd, 32'hCC);
    // interrupt: raised, cleared by read, then masked
    check("irq raised", {31'h0, irq}, 32'h1);
    axi_read(`RRS_A_IRQ_STAT, rd, rs);
    check("irq events", rd, 32'h3);
    repeat (2) @(posedge aclk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    wr(`RRS_A_IRQ_MASK, 32'h0);
    send_op({`RRS_ROTL_HI, 1'b0, 7'h7F});
    repeat (3) @(posedge aclk);
    check("irq masked", {31'h0, irq}, 32'h0);
    axi_read(`RRS_A_IRQ_STAT, rd, rs);
    check("masked event", rd, 32'h2);
    axi_read(`RRS_A_WREG, rd, rs);
    check("rotate with carry in", rd, 32'h9B);
    // let the watchdog count so that the sleep clear has something to undo
    repeat (300) @(posedge aclk);
    axi_read(`RRS_A_WDOG, rd, rs);
    check("watchdog running", {31'h0, rd[7:0] != 8'h00}, 32'h1);
    // sleep
    send_op(`RRS_OP_SLEEP);
    after_op(13'h077A, 1'b0);
    check("oscillator", {31'h0, osc_run}, 32'h0);
    axi_read(`RRS_A_STATUS, rd, rs);
    check("timeout flag", {31'h0, rd[4]}, 32'h1);
    check("power down flag", {31'h0, rd[3]}, 32'h0);
    axi_read(`RRS_A_WDOG, rd, rs);
    check("watchdog counter", {24'h0, rd[7:0]}, 32'h0);
    check("prescaler low", {31'h0, rd[15:8] < 8'h08}, 32'h1);
    check("still asleep", {31'h0, opcode_ready}, 32'h0);
    wr(`RRS_A_CTRL, 32'h1);
    @(posedge aclk);
    check("oscillator restart", {31'h0, osc_run}, 32'h1);
    // an opcode outside this group only advances the program counter
    send_op(14'h0000);
    after_op(13'h077B, 1'b1);
    // unmapped and misaligned accesses
    axi_read(8'h30, rd, rs);
    check("unmapped data", rd, 32'h0);
    check("unmapped read resp", {30'h0, rs}, {30'h0, `RRS_RESP_SLVERR});
    axi_read(8'h02, rd, rs);
    check("misaligned resp", {30'h0, rs}, {30'h0, `RRS_RESP_SLVERR});
    axi_write(8'h2C, 32'hFFFF, rs);
    check("unmapped write resp", {30'h0, rs}, {30'h0, `RRS_RESP_SLVERR});
    results();
  end
endmodule
